// ===== include/fxs_pkg.sv
// Package for the SIMD floating-point exception signalling unit.
// Assumes a single core clock domain and no register bus.
package fxs_pkg;

  // Lane and flag counts
  localparam int FXS_NUM_LANES = 4;
  localparam int FXS_NUM_FLAGS = 6;

  // Flag and mask bit positions
  localparam int FXS_FLG_IE = 0; // Invalid operation
  localparam int FXS_FLG_DE = 1; // Denormal operand
  localparam int FXS_FLG_ZE = 2; // Divide by zero
  localparam int FXS_FLG_OE = 3; // Overflow
  localparam int FXS_FLG_UE = 4; // Underflow
  localparam int FXS_FLG_PE = 5; // Inexact

  // Dispatch vector for an unmasked numeric exception
  localparam logic [7:0] FXS_FAULT_VECTOR = 8'h13;

  // Reset value of the control/status word: all masks set, flags clear
  localparam logic [13:0] FXS_CSR_RESET = 14'h1F80;

  // Six exception bits, one per condition
  typedef logic [FXS_NUM_FLAGS-1:0] fxs_flags_t;

  // Control/status word
  typedef struct packed {
    logic ftz;          // Flush results to zero
    fxs_flags_t mask;   // One mask bit per condition, 1 = masked
    logic daz;          // Treat denormal inputs as zero
    fxs_flags_t flags;  // Sticky status flags
  } fxs_csr_t;

  // One SIMD instruction reaching the exception stage
  typedef struct packed {
    logic valid;                               // Instruction present
    logic [31:0] ip;                           // Address of this instruction
    logic [FXS_NUM_LANES-1:0] lane_en;         // Lanes in use (scalar: lane 0)
    fxs_flags_t [FXS_NUM_LANES-1:0] pre_flags; // Conditions seen before compute
    fxs_flags_t [FXS_NUM_LANES-1:0] post_flags; // Conditions seen after compute
  } fxs_op_t;

endpackage

// ===== src/fxs_lane_eval.sv
// Per-lane exception classifier for the SIMD exception unit.
// Assumes flags arrive already split into before- and after-compute groups.
`timescale 1ns/1ps
`default_nettype none

module fxs_lane_eval
  import fxs_pkg::*;
(
  input wire logic lane_en,
  input wire fxs_pkg::fxs_flags_t pre_in,
  input wire fxs_pkg::fxs_flags_t post_in,
  input wire fxs_pkg::fxs_flags_t mask,
  input wire logic daz,
  output fxs_pkg::fxs_flags_t pre_seen,
  output fxs_pkg::fxs_flags_t post_seen,
  output logic pre_unmasked,
  output logic post_unmasked
);

  // Only before-compute conditions may be faults
  localparam fxs_flags_t PRE_SET = fxs_flags_t'((1 << FXS_FLG_IE) | (1 << FXS_FLG_DE)
    | (1 << FXS_FLG_ZE));
  // Only after-compute conditions may be traps
  localparam fxs_flags_t POST_SET = fxs_flags_t'((1 << FXS_FLG_OE) | (1 << FXS_FLG_UE)
    | (1 << FXS_FLG_PE));
  // Denormal bit alone
  localparam fxs_flags_t DE_BIT = fxs_flags_t'(1 << FXS_FLG_DE);

  // Classify this lane's conditions
  always_comb
  begin
    // An idle lane contributes nothing
    pre_seen = lane_en ? (pre_in & PRE_SET) : '0; // RL10 RL12
    // Inputs treated as zero never report a denormal operand
    if (daz)
    begin
      pre_seen = pre_seen & ~DE_BIT; // RL7
    end
    post_seen = lane_en ? (post_in & POST_SET) : '0; // RL10 RL12
    // Each condition is gated by its own mask bit
    pre_unmasked = |(pre_seen & ~mask); // RL8
    post_unmasked = |(post_seen & ~mask); // RL8
  end

endmodule

`default_nettype wire

// ===== src/fxs_exc_unit.sv
// SIMD floating-point exception signalling unit: merges lane flags,
// decides between masked default results and a precise dispatch request.
// Assumes the pipeline holds an instruction while op_ready is low and the
// dispatch logic acknowledges a request once it has entered the handler.
//
// What this block does
// (RL1) Unmasked exception dispatches through vector 19
// (RL2) Stale set flag never raises an exception
// (RL3) Exceptions precise, signalled at the excepting instruction
// (RL4) No interlock with integer or other units
// (RL5) Status flags are OR of lane flags
// (RL6) Unmasked exception delivers no result
// (RL7) Standard arithmetic unless flush or denormal-zero
// (RL8) Independent mask for each of six conditions
// (RL9) Interrupt gate entry clears interrupt permit flag
// (RL10) Up to four lanes contribute conditions
// (RL11) Masked exception: default result, flag, no signal
// (RL12) Faults before compute, traps after compute
// (RL13) Unmasked lane suppresses all writes, flags update
// (RL14) Saved pointer names the excepting instruction
`timescale 1ns/1ps
`default_nettype none

module fxs_exc_unit
  import fxs_pkg::*;
#(
  parameter int NUM_LANES = fxs_pkg::FXS_NUM_LANES
)
(
  input wire logic core_clk,
  input wire logic rst_n,
  input wire fxs_pkg::fxs_op_t op_i,
  output logic op_ready,
  input wire logic csr_wr_en,
  input wire fxs_pkg::fxs_csr_t csr_wr_data,
  output fxs_pkg::fxs_csr_t csr,
  output logic wb_en,
  output logic [NUM_LANES-1:0] wb_default,
  output logic exc_req,
  output logic [7:0] exc_vector,
  output logic [31:0] exc_ip,
  output logic exc_fault,
  input wire logic dispatch_ack,
  input wire logic gate_is_intr,
  output logic if_clear
);

  // Per-lane classifier results
  fxs_flags_t pre_l [NUM_LANES]; // Before-compute conditions per lane
  fxs_flags_t post_l [NUM_LANES]; // After-compute conditions per lane
  logic [NUM_LANES-1:0] pre_unm; // Lane holds an unmasked fault
  logic [NUM_LANES-1:0] post_unm; // Lane holds an unmasked trap
  // Merged results
  fxs_flags_t pre_or; // OR of fault conditions over lanes
  fxs_flags_t post_or; // OR of trap conditions over lanes
  fxs_flags_t new_flags; // Flags this instruction sets
  logic fault_any; // Some lane faults
  logic trap_eff; // Some lane traps and nothing faulted
  logic unm_any; // Instruction must be dispatched
  logic [NUM_LANES-1:0] lane_dflt; // Lane takes a masked default result
  logic acc; // Instruction taken this cycle
  // State
  fxs_csr_t csr_r; // Control/status word
  logic pending_r; // Dispatch request outstanding
  logic pending_nxt; // Next value of the request
  logic ready_r; // Stage accepts instructions
  logic wb_en_r; // Result write permitted
  logic [NUM_LANES-1:0] wb_default_r; // Per-lane default result select
  logic [7:0] vector_r; // Dispatch vector
  logic [31:0] ip_r; // Pointer of the excepting instruction
  logic fault_r; // Exception was a fault, not a trap
  logic if_clear_r; // Clear interrupt permit flag

  // One classifier per lane
  genvar gi;
  generate
    for (gi = 0; gi < NUM_LANES; gi++)
    begin : g_lane
      fxs_lane_eval u_eval (
        .lane_en(op_i.lane_en[gi]),
        .pre_in(op_i.pre_flags[gi]),
        .post_in(op_i.post_flags[gi]),
        .mask(csr_r.mask),
        .daz(csr_r.daz),
        .pre_seen(pre_l[gi]),
        .post_seen(post_l[gi]),
        .pre_unmasked(pre_unm[gi]),
        .post_unmasked(post_unm[gi])
      );
    end
  endgenerate

  // Merge lanes and decide the outcome of the current instruction
  always_comb
  begin
    pre_or = '0;
    post_or = '0;
    // Packed flags are the OR of every lane
    for (int i = 0; i < NUM_LANES; i++)
    begin
      pre_or = pre_or | pre_l[i]; // RL5
      post_or = post_or | post_l[i]; // RL5
    end
    fault_any = |pre_unm;
    // A fault stops the computation, so no trap can follow it
    trap_eff = (|post_unm) & ~fault_any; // RL12
    // Only conditions of this instruction count, never the sticky flags
    unm_any = fault_any | trap_eff; // RL2
    // Trap conditions are only reported when computation went ahead
    new_flags = fault_any ? pre_or : (pre_or | post_or); // RL12 RL13
    // Masked lanes substitute the default result
    for (int i = 0; i < NUM_LANES; i++)
    begin
      lane_dflt[i] = ~unm_any & (|(pre_l[i] | post_l[i])); // RL11
    end
  end

  // Accept depends on this unit alone, no cross-unit synchronisation
  assign acc = op_i.valid & ready_r; // RL4

  // Request set on an unmasked exception, held until dispatch takes it
  always_comb
  begin
    pending_nxt = pending_r;
    if (pending_r && dispatch_ack)
    begin
      pending_nxt = 1'b0;
    end
    if (acc && unm_any)
    begin
      pending_nxt = 1'b1; // RL3
    end
  end

  // Control/status word: software load, hardware flag set wins
  always_ff @(posedge core_clk)
  begin
    if (!rst_n)
    begin
      csr_r <= fxs_csr_t'(FXS_CSR_RESET);
    end
    else
    begin
      if (csr_wr_en)
      begin
        csr_r <= csr_wr_data;
      end
      // Flags update even when the write is suppressed
      if (acc)
      begin
        csr_r.flags <= (csr_wr_en ? csr_wr_data.flags : csr_r.flags) | new_flags; // RL5 RL13
      end
    end
  end

  // Dispatch request and stage readiness
  always_ff @(posedge core_clk)
  begin
    if (!rst_n)
    begin
      pending_r <= 1'b0;
      ready_r <= 1'b1;
    end
    else
    begin
      pending_r <= pending_nxt; // RL1 RL3
      // Younger instructions wait until the handler is entered
      ready_r <= ~pending_nxt; // RL3 RL4
    end
  end

  // Captured exception details for the dispatch logic
  always_ff @(posedge core_clk)
  begin
    if (!rst_n)
    begin
      vector_r <= 8'h00;
      ip_r <= 32'h0000_0000;
      fault_r <= 1'b0;
    end
    else if (acc && unm_any)
    begin
      vector_r <= FXS_FAULT_VECTOR; // RL1
      // Pointer of this instruction, not of the next one
      ip_r <= op_i.ip; // RL14
      fault_r <= fault_any; // RL12
    end
  end

  // Result write control, one pulse per accepted instruction with no unmasked exception
  always_ff @(posedge core_clk)
  begin
    if (!rst_n)
    begin
      wb_en_r <= 1'b0;
      wb_default_r <= '0;
    end
    else
    begin
      // Any unmasked lane cancels the whole destination write
      wb_en_r <= acc & ~unm_any; // RL6 RL11 RL13
      wb_default_r <= acc ? lane_dflt : '0; // RL11
    end
  end

  // Interrupt permit flag cleared when an interrupt gate is used
  always_ff @(posedge core_clk)
  begin
    if (!rst_n)
    begin
      if_clear_r <= 1'b0;
    end
    else
    begin
      if_clear_r <= pending_r & dispatch_ack & gate_is_intr; // RL9
    end
  end

  // Outputs straight from flip-flops
  assign op_ready = ready_r;
  assign csr = csr_r;
  assign wb_en = wb_en_r;
  assign wb_default = wb_default_r;
  assign exc_req = pending_r;
  assign exc_vector = vector_r;
  assign exc_ip = ip_r;
  assign exc_fault = fault_r;
  assign if_clear = if_clear_r;

  // Checks
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_n);

  // Steps of a dispatch
  sequence s_raise;
    acc && unm_any;
  endsequence
  sequence s_hold;
    exc_req && !op_ready;
  endsequence
  sequence s_enter;
    exc_req && dispatch_ack && gate_is_intr;
  endsequence

  vector_value_a: assert property ($rose(exc_req) |-> exc_vector == 8'h13) // RL1
    else $error("dispatch vector wrong");
  stale_flag_a: assert property (acc && !unm_any |=> !exc_req) // RL2
    else $error("exception without new condition");
  precise_raise_a: assert property (s_raise |=> s_hold) // RL3
    else $error("exception not raised at instruction");
  no_interlock_a: assert property (op_ready != exc_req) // RL4
    else $error("stall without pending exception");
  flag_merge_a: assert property (acc && !csr_wr_en |=> // RL5
    csr.flags == ($past(csr.flags) | $past(new_flags)))
    else $error("flag merge wrong");
  // A software load in the same cycle as a taken op must not lose the new flags
  flag_clash_a: assert property (acc && csr_wr_en |=> // RL5
    csr.flags == ($past(csr_wr_data.flags) | $past(new_flags)))
    else $error("flag set lost to software load");
  no_result_a: assert property (s_raise |=> !wb_en && wb_default == '0) // RL6
    else $error("result written on unmasked exception");
  mask_select_a: assert property (acc |-> // RL8
    unm_any == (|((pre_or & ~csr.mask) | (post_or & ~csr.mask))))
    else $error("mask gating wrong");
  gate_clear_a: assert property (s_enter |=> if_clear && !exc_req) // RL9
    else $error("permit flag not cleared");
  masked_default_a: assert property (acc && !unm_any |=> wb_en && !exc_req) // RL11
    else $error("masked exception signalled");
  fault_kind_a: assert property (acc && fault_any |=> exc_fault ##0 exc_req) // RL12
    else $error("fault not classed as fault");
  suppress_flags_a: assert property ((s_raise and !csr_wr_en) |=> // RL13
    !wb_en && ((csr.flags & $past(new_flags)) == $past(new_flags)))
    else $error("flags lost on suppressed write");
  saved_ip_a: assert property (s_raise |=> exc_ip == $past(op_i.ip) // RL14
    ##1 (exc_ip == $past(exc_ip) || !exc_req))
    else $error("saved pointer wrong");

endmodule

`default_nettype wire

// ===== sim/fxs_dispatch_model.sv
// Model of the interrupt dispatch that answers exception requests.
// Assumes exc_req is a level held until acknowledged; one core clock.
`timescale 1ns/1ps
`default_nettype none
module fxs_dispatch_model
(
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic exc_req,
  input wire logic [3:0] dly,
  input wire logic gate_sel,
  output logic dispatch_ack,
  output logic gate_is_intr
);
  logic [3:0] wait_r; // Cycles spent on the pending request
  // Acknowledge after the chosen delay, as a one cycle pulse
  always_ff @(posedge core_clk)
  begin
    if (!rst_n)
    begin
      wait_r <= 4'h0;
      dispatch_ack <= 1'b0;
    end
    else if (dispatch_ack || !exc_req)
    begin
      wait_r <= 4'h0;
      dispatch_ack <= 1'b0;
    end
    else if (wait_r == dly)
      dispatch_ack <= 1'b1;
    else
      wait_r <= wait_r + 4'h1;
  end
  // Gate kind only means something with the acknowledge; toggles otherwise
  assign gate_is_intr = dispatch_ack ? gate_sel : ~wait_r[0];
endmodule
`default_nettype wire

// ===== sim/fxs_exc_unit_tb.sv
// Self-checking bench for the SIMD exception signalling unit.
// Assumes the package and the dispatch model are compiled first.
`timescale 1ns/1ps
`default_nettype none
module fxs_exc_unit_tb;
  import fxs_pkg::*;
  logic core_clk = 1'b0; // 100 MHz core clock
  logic rst_n = 1'b0;
  fxs_op_t op_i = '0;
  logic csr_wr_en = 1'b0;
  fxs_csr_t csr_wr_data = '0;
  logic [3:0] dly = 4'h0; // Dispatch answer delay
  logic gate_sel = 1'b1; // Handler entered through an interrupt gate
  logic op_ready, wb_en, exc_req, exc_fault, dispatch_ack, gate_is_intr, if_clear;
  logic [3:0] wb_default;
  logic [7:0] exc_vector;
  logic [31:0] exc_ip;
  fxs_csr_t csr;
  int fails = 0;
  int checks_done = 0;
  // Clock generator
  always #5 core_clk = ~core_clk;
  fxs_exc_unit i_dut (.core_clk(core_clk), .rst_n(rst_n), .op_i(op_i), .op_ready(op_ready),
    .csr_wr_en(csr_wr_en), .csr_wr_data(csr_wr_data), .csr(csr), .wb_en(wb_en),
    .wb_default(wb_default), .exc_req(exc_req), .exc_vector(exc_vector), .exc_ip(exc_ip),
    .exc_fault(exc_fault), .dispatch_ack(dispatch_ack), .gate_is_intr(gate_is_intr),
    .if_clear(if_clear));
  fxs_dispatch_model i_disp (.core_clk(core_clk), .rst_n(rst_n), .exc_req(exc_req),
    .dly(dly), .gate_sel(gate_sel), .dispatch_ack(dispatch_ack), .gate_is_intr(gate_is_intr));
  // Verdict and end of run
  task automatic stop_test();
    $display("checks_done=%0d fails=%0d", checks_done, fails);
    if (fails == 0 && checks_done > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  // Compare one value
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp)
    begin
      fails++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // Load the control/status word and read it back
  task automatic wr_csr(input fxs_flags_t msk, input logic dz, input fxs_flags_t flg);
    fxs_csr_t v;
    v = '{ftz: dz, mask: msk, daz: dz, flags: flg};
    @(posedge core_clk);
    csr_wr_en <= 1'b1;
    csr_wr_data <= v;
    @(posedge core_clk);
    csr_wr_en <= 1'b0;
    #1;
    chk(32'(csr), 32'(v));
  endtask
  // Issue one op, judge its answer and any dispatch handshake
  task automatic do_op(input logic [31:0] ip, input logic [3:0] en, input logic [23:0] pre,
    input logic [23:0] post, input logic exc, input logic flt, input fxs_flags_t flg,
    input logic [3:0] wbd);
    int n;
    @(posedge core_clk);
    op_i <= '{valid: 1'b1, ip: ip, lane_en: en, pre_flags: pre, post_flags: post};
    @(posedge core_clk);
    op_i.valid <= 1'b0;
    #1;
    chk(exc_req, exc);
    chk(wb_en, !exc);
    chk(wb_default, wbd);
    chk(csr.flags, flg);
    if (exc)
    begin
      chk(exc_vector, 8'h13);
      chk(exc_ip, ip);
      chk(exc_fault, flt);
      chk(op_ready, 1'b0);
      n = 0;
      while (exc_req !== 1'b0 && n < 20)
      begin
        @(posedge core_clk);
        #1;
        n++;
      end
      if (n == 20)
      begin
        fails++;
        stop_test();
      end
      chk(if_clear, gate_sel);
      chk(op_ready, 1'b1);
    end
  endtask
  // Values seen right after reset
  task automatic t_reset();
    chk(32'(csr), 32'h1F80);
    chk(op_ready, 1'b1);
    chk(exc_req, 1'b0);
    chk(wb_en, 1'b0);
  endtask
  // Masked packed op with one lane disabled
  task automatic t_masked();
    wr_csr(6'h3F, 1'b0, 6'h00);
    do_op(32'h1000, 4'hB, 24'h004001, 24'h400800, 1'b0, 1'b0, 6'h31, 4'hB);
  endtask
  // Each condition unmasked alone, masked noise in another lane
  task automatic t_each();
    for (int b = 0; b < 6; b++)
    begin
      dly <= 4'(b);
      gate_sel <= b[0];
      wr_csr(~(6'h01 << b), 1'b0, 6'h00);
      if (b < 3)
        do_op(32'(32'h2000 + b), 4'h9, 24'(6'h01 << b) << 18, 24'h000020, 1'b1, 1'b1,
          6'h01 << b, 4'h0);
      else
        do_op(32'(32'h2000 + b), 4'h9, 24'h000001, 24'(6'h01 << b) << 18, 1'b1, 1'b0,
          (6'h01 << b) | 6'h01, 4'h0);
    end
  endtask
  // Flags already set with all masks clear raise nothing
  task automatic t_stale();
    wr_csr(6'h00, 1'b0, 6'h3F);
    do_op(32'h3000, 4'hF, 24'h0, 24'h0, 1'b0, 1'b0, 6'h3F, 4'h0);
  endtask
  // Denormal input treated as zero raises no denormal condition
  task automatic t_daz();
    wr_csr(6'h3D, 1'b1, 6'h00);
    do_op(32'h4000, 4'h1, 24'h000002, 24'h000020, 1'b0, 1'b0, 6'h20, 4'h1);
  endtask
  // Two ops in consecutive cycles with no stall
  task automatic t_b2b();
    wr_csr(6'h3F, 1'b0, 6'h00);
    @(posedge core_clk);
    op_i <= '{valid: 1'b1, ip: 32'h5000, lane_en: 4'h1, pre_flags: 24'h4, post_flags: 24'h0};
    @(posedge core_clk);
    op_i <= '{valid: 1'b1, ip: 32'h5004, lane_en: 4'h2, pre_flags: 24'h0, post_flags: 24'h800};
    #1;
    chk(wb_default, 4'h1);
    @(posedge core_clk);
    op_i.valid <= 1'b0;
    #1;
    chk(wb_default, 4'h2);
    chk(csr.flags, 6'h24);
  endtask
  // Software clears flags in the cycle an op sets one: the set wins
  task automatic t_clash();
    wr_csr(6'h3F, 1'b0, 6'h3F);
    @(posedge core_clk);
    op_i <= '{valid: 1'b1, ip: 32'h6000, lane_en: 4'h1, pre_flags: 24'h1, post_flags: 24'h0};
    csr_wr_en <= 1'b1;
    csr_wr_data <= '{ftz: 1'b0, mask: 6'h3F, daz: 1'b0, flags: 6'h00};
    @(posedge core_clk);
    op_i.valid <= 1'b0;
    csr_wr_en <= 1'b0;
    #1;
    chk(csr.flags, 6'h01);
    chk(wb_default, 4'h1);
  endtask
  // Main sequence
  initial
  begin
    repeat (10) @(posedge core_clk);
    rst_n <= 1'b1;
    #1;
    t_reset();
    t_masked();
    t_each();
    t_stale();
    t_daz();
    t_b2b();
    t_clash();
    stop_test();
  end
endmodule
`default_nettype wire
